// ---- sdl_ddr_serdes_link.sv ----
/*
 * sdl_ddr_serdes_link: sixteen-lane 8:1 DDR serializer and 1:8 deserializer
 * for a card-to-card backplane link, with a receive word fifo.
 * Assumes clk_in is the quad-rate clock for transmit and, for receive, the
 * phase-shifted forwarded clock; DDR pins arrive and leave as rise/fall bit
 * pairs, one pair per clock cycle, synchronous to clk_in.
 */
`timescale 1ns/1ps

// Function
// - transmit 128-bit word onto sixteen lanes
// - transmitter built from four standalone four-lane slices
// - every slice brings out clock and frame
// - each lane deserialized to bytes through fifo
// - one forwarded clock and frame per transmit slice, one receive frame per link
// - receive clock phase shift fixed at power-up
// - capture two bits per receive clock period
// - re-register both edge streams before demultiplexing
// - demultiplex edge streams into eight bits per lane
// - bytes written into block-memory word fifo
// - fifo flags quarter, half, three-quarter full
// - frame line aligns byte boundaries and bit order
// - write strobe qualifies receive clock, no divided clock
// - fifo read side decoupled from receive timing
// - four lanes form one 32-bit receive group
// - four groups give 128-bit receive word
// - quad-rate clock is exactly four times the system clock rate
// - register bytes, multiplex onto ddr outputs
// - forwarded clock from ddr constant high/low
// - frame high four of eight half periods
module sdl_ddr_serdes_link
	import sdl_pkg::*;
#(
	parameter int           LANES       = SDL_LANES,
	parameter int           FIFO_ADDR   = SDL_FIFO_ADDR_BITS,
	parameter logic [7:0]   PHASE_SHIFT = SDL_PHASE_QUARTER
) (
	input  wire logic                       clk_in,
	input  wire logic                       reset_n_in,
	// transmit side
	input  wire logic [LANES*8-1:0]         tx_word_in,
	output logic      [SDL_SLICES-1:0]      tx_word_take_out,
	output sdl_ddr_t  [LANES-1:0]           tx_lane_out,
	output sdl_ddr_t  [SDL_SLICES-1:0]      tx_fwd_clock_out,
	output sdl_ddr_t  [SDL_SLICES-1:0]      tx_frame_out,
	// receive side
	input  wire sdl_ddr_t [LANES-1:0]       rx_lane_in,
	input  wire sdl_ddr_t                   rx_frame_in,
	input  wire logic                       rx_frame_enable_in,
	output logic [7:0]                      rx_phase_shift_out,
	output logic                            rx_frame_locked_out,
	// receive fifo read side
	input  wire logic                       rx_read_in,
	output logic [LANES*8-1:0]              rx_read_data_out,
	output logic                            rx_read_valid_out,
	output logic                            rx_overflow_out,
	output sdl_fill_t                       rx_fill_out
);

	localparam int SLICE_LANES = SDL_SLICE_LANES;
	localparam int GROUPS      = LANES / SLICE_LANES;

	// ****************************************************************
	// transmit slices
	// ****************************************************************
	// each slice runs standalone on its own quarter of the word; all
	// slices share the reset so their slot counters stay in step
	for (genvar s = 0; s < GROUPS; s++) begin : g_tx_slice
		sdl_four_lane_serializer #(
			.LANES          (SLICE_LANES)
		) u_slice (
			.clk_in         (clk_in),
			.reset_n_in     (reset_n_in),
			.word_in        (tx_word_in[s*SLICE_LANES*8 +: SLICE_LANES*8]),
			.word_take_out  (tx_word_take_out[s]),
			.lane_out       (tx_lane_out[s*SLICE_LANES +: SLICE_LANES]),
			.fwd_clock_out  (tx_fwd_clock_out[s]),
			.frame_out      (tx_frame_out[s])
		);
	end

	// ****************************************************************
	// receive state
	// ****************************************************************
	typedef struct packed {
		logic [7:0]              phase_shift;
		sdl_ddr_t [LANES-1:0]    capture;
		sdl_ddr_t [LANES-1:0]    retimed;
		sdl_ddr_t                frame_capture;
		sdl_ddr_t                frame_retimed;
		sdl_ddr_t                frame_prev;
		logic [1:0]              slot;
		logic                    locked;
		logic [LANES*8-1:0]      assembled;
		logic                    write;
	} sdl_rx_state_t;

	sdl_rx_state_t state;
	sdl_rx_state_t next_state;
	logic          word_start;
	logic [1:0]    slot_now;

	// ****************************************************************
	// frame boundary detection
	// ****************************************************************
	// a low-to-high frame step marks bits 0 and 1 of a new byte; the
	// frame goes through the same two stages as data so they line up
	always_comb begin
		word_start = rx_frame_enable_in &&
			(state.frame_retimed == SDL_DDR_HIGH) &&
			(state.frame_prev == SDL_DDR_LOW);
		slot_now   = word_start ? SDL_SLOT_FIRST : state.slot;
	end

	// ****************************************************************
	// capture, retime and demultiplex
	// ****************************************************************
	always_comb begin
		next_state = state;
		// the phase value is a constant loaded once after reset
		next_state.phase_shift   = PHASE_SHIFT;
		next_state.capture       = rx_lane_in;
		next_state.retimed       = state.capture;
		next_state.frame_capture = rx_frame_in;
		next_state.frame_retimed = state.frame_capture;
		next_state.frame_prev    = state.frame_retimed;
		// lanes are filled in place; groups of four lanes form 32-bit words
		for (int l = 0; l < LANES; l++) begin
			next_state.assembled[l*8 + 2*int'(slot_now)]     =
				state.retimed[l].rise;
			next_state.assembled[l*8 + 2*int'(slot_now) + 1] =
				state.retimed[l].fall;
		end
		next_state.slot  = slot_now + SDL_SLOT_STEP;
		// one strobe per completed byte on every lane, no second clock; with
		// framing on nothing is written before the first boundary, so the fifo
		// never holds a word cut across two transmitted words
		next_state.write = (slot_now == SDL_SLOT_LAST) &&
			(!rx_frame_enable_in || state.locked);
		// lock shows that a boundary has been seen since framing was enabled
		if (!rx_frame_enable_in) begin
			next_state.locked = 1'b0;
		end else if (word_start) begin
			next_state.locked = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// receive fifo
	// ****************************************************************
	// the assembled word is complete in the cycle the strobe is high;
	// slot 0 of the next byte only overwrites it at the following edge
	sdl_rx_fifo #(
		.WIDTH          (LANES*8),
		.ADDR_BITS      (FIFO_ADDR)
	) u_fifo (
		.clk_in         (clk_in),
		.reset_n_in     (reset_n_in),
		.write_in       (state.write),
		.write_data_in  (state.assembled),
		.read_in        (rx_read_in),
		.read_data_out  (rx_read_data_out),
		.read_valid_out (rx_read_valid_out),
		.overflow_out   (rx_overflow_out),
		.fill_out       (rx_fill_out)
	);

	assign rx_phase_shift_out  = state.phase_shift;
	assign rx_frame_locked_out = state.locked;

endmodule : sdl_ddr_serdes_link

// ---- sdl_ddr_serdes_link_tb_top.sv ----
/* bench for the serdes link: transmit slots, then receive fill and drain.
   assumes the far card model drives the receive pins from the same clock. */
`timescale 1ns/1ps
module sdl_ddr_serdes_link_tb_top
	import sdl_pkg::*;
;
	logic            clk_in = 1'b0;
	logic            reset_n_in = 1'b0;
	logic [127:0]    tx_word = '0;
	logic [127:0]    got;
	logic [127:0]    rdata;
	logic [3:0]      take;
	sdl_ddr_t [15:0] tx_lane;
	sdl_ddr_t [15:0] rx_lane;
	sdl_ddr_t [3:0]  fwd;
	sdl_ddr_t [3:0]  frm;
	sdl_ddr_t        rx_frame;
	logic [7:0]      phase;
	logic            locked;
	logic            rd = 1'b0;
	logic            go = 1'b0;
	logic            frm_en = 1'b0;
	logic            rvalid;
	logic            ovf;
	sdl_fill_t       fill;
	logic [15:0]     sent;
	int              fails = 0;
	int              tests_run = 0;

	always #4 clk_in = ~clk_in;

	sdl_ddr_serdes_link dut (
		.clk_in, .reset_n_in, .tx_word_in(tx_word), .tx_word_take_out(take),
		.tx_lane_out(tx_lane), .tx_fwd_clock_out(fwd), .tx_frame_out(frm),
		.rx_lane_in(rx_lane), .rx_frame_in(rx_frame), .rx_frame_enable_in(frm_en),
		.rx_phase_shift_out(phase), .rx_frame_locked_out(locked), .rx_read_in(rd),
		.rx_read_data_out(rdata), .rx_read_valid_out(rvalid),
		.rx_overflow_out(ovf), .rx_fill_out(fill)
	);
	// one frame line shared by all lanes
	sdl_far_card far (
		.clk_in, .go_in(go), .lane_out(rx_lane), .frame_out(rx_frame), .sent_out(sent)
	);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [127:0] pattern(input int i);
		return {4{i[15:0], ~i[15:0]}};
	endfunction : pattern

	task automatic tick;
		@(posedge clk_in);
		#1;
	endtask : tick

	task automatic check(input string what, input logic [127:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wait_sent(input logic [15:0] n);
		for (int k = 0; k < 4000 && sent !== n; k++)
			tick();
		check("sent count", sent, n);
	endtask : wait_sent

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : report_and_stop

	// ****************************************************************
	// tests
	// ****************************************************************
	initial begin
		repeat (12) @(posedge clk_in);
		#1;
		check("reset fill", fill, 5'h01);
		check("reset take", take, 4'hf);
		reset_n_in = 1'b1;
		// two words back to back, rebuilt from the lane pairs
		for (int w = 0; w < 2; w++) begin
			// the second word goes msb first, reversed as the integrator would
			got = pattern(w + 7);
			if (w == 1)
				got = {<<{got}};
			tx_word = got;
			for (int k = 0; k < 8 && take[0] !== 1'b1; k++)
				tick();
			for (int s = 0; s < 4; s++) begin
				tick();
				for (int l = 0; l < 16; l++)
					{got[8*l+2*s], got[8*l+2*s+1]} = tx_lane[l];
				check("tx frame", frm, (s < 2) ? 8'hff : 8'h00);
			end
			check("tx word", got, tx_word);
		end
		check("fwd clock", fwd, 8'haa);
		check("phase", phase, SDL_PHASE_QUARTER);
		$display("test tx done");
		// framing off: the free-running strobe still writes, and nothing locks
		check("unframed lock", locked, 1'b0);
		check("unframed write", fill.empty, 1'b0);
		// a mid-run reset clears the fifo before the framed stream starts
		reset_n_in = 1'b0;
		tick();
		check("reset refill", fill, 5'h01);
		check("reset lock", locked, 1'b0);
		reset_n_in = 1'b1;
		frm_en = 1'b1;
		$display("test rx reset done");
		// the write count lags the far card by about one word (four cycles), so sample either side
		go = 1'b1;
		for (int q = 1; q <= 4; q++) begin
			wait_sent(16'(128 * q));
			check("fill flag below", fill[5-q], 1'b0);
			check("no overflow", ovf, 1'b0);
			wait_sent(16'(128 * q + 4));
			check("fill flag at", fill[5-q], 1'b1);
		end
		check("frame lock", locked, 1'b1);
		wait_sent(16'd520);
		check("overflow", ovf, 1'b1);
		$display("test rx fill done");
		// back to back reads; the first 512 words must come out in order
		rd = 1'b1;
		for (int i = 0; i < 512; i++) begin
			tick();
			check("read valid", rvalid, 1'b1);
			check("read data", rdata, pattern(i));
		end
		// the far card keeps streaming, so reads outrun a write every fourth cycle
		for (int k = 0; k < 400 && fill.empty !== 1'b1; k++)
			tick();
		check("drained", fill.empty, 1'b1);
		tick();
		rd = 1'b0;
		check("read at empty", rvalid, 1'b0);
		$display("test rx read done");
		report_and_stop();
	end

	// the run needs about 3000 cycles; this allows roughly four times that
	initial begin
		#100000;
		fails++;
		report_and_stop();
	end
endmodule : sdl_ddr_serdes_link_tb_top

// ---- sdl_far_card.sv ----
/* far card model: a serializer streaming numbered words to the receive pins.
   assumes the bench clock; streams without a break once started. */
`timescale 1ns/1ps
module sdl_far_card
	import sdl_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       go_in,
	output sdl_ddr_t [15:0] lane_out,
	output sdl_ddr_t        frame_out,
	output logic [15:0]     sent_out
);
	logic [127:0] word;
	int           slot = 0;
	logic         run;

	// ****************************************************************
	// serializer
	// ****************************************************************
	initial begin
		lane_out = '0;
		frame_out = SDL_DDR_LOW;
		sent_out = 16'h0;
	end

	// idle lanes toggle so a stale pair never passes for data
	// go is taken at the edge so a bench change just after it cannot race
	always @(posedge clk_in) begin
		run = go_in;
		#1;
		if (run) begin
			if (slot == 0)
				word = {4{sent_out, ~sent_out}};
			frame_out = (slot < 2) ? SDL_DDR_HIGH : SDL_DDR_LOW;
			for (int l = 0; l < 16; l++)
				lane_out[l] = {word[8*l+2*slot], word[8*l+2*slot+1]};
			if (slot == 3)
				sent_out <= sent_out + 16'h1;
			slot = (slot + 1) % 4;
		end else begin
			frame_out = SDL_DDR_LOW;
			lane_out = ~lane_out;
		end
	end
endmodule : sdl_far_card

// ---- sdl_four_lane_serializer.sv ----
/*
 * sdl_four_lane_serializer: one standalone 4-lane 8:1 slice. Takes a 32-bit
 * word once every four quad-rate cycles and drives four DDR lanes plus its own
 * forwarded clock and frame.
 * Assumes clk_in is the quad-rate clock and the system clock is its exact
 * quarter, aligned to word_take_out.
 */
`timescale 1ns/1ps
module sdl_four_lane_serializer
	import sdl_pkg::*;
#(
	parameter int LANES = SDL_SLICE_LANES
) (
	input  wire logic                      clk_in,
	input  wire logic                      reset_n_in,
	input  wire logic [LANES*8-1:0]        word_in,
	output logic                           word_take_out,
	output sdl_ddr_t  [LANES-1:0]          lane_out,
	output sdl_ddr_t                       fwd_clock_out,
	output sdl_ddr_t                       frame_out
);

	typedef struct packed {
		logic [1:0]              slot;
		logic [LANES*8-1:0]      word;
		sdl_ddr_t [LANES-1:0]    lane;
		sdl_ddr_t                fwd;
		sdl_ddr_t                frame;
	} sdl_ser_state_t;

	sdl_ser_state_t state;
	sdl_ser_state_t next_state;
	logic [LANES*8-1:0] source;

	// ****************************************************************
	// word load and bit multiplexing
	// ****************************************************************
	// the fresh word is used directly in slot 0 so there is no dead slot
	always_comb begin
		next_state = state;
		source     = (state.slot == SDL_SLOT_FIRST) ? word_in : state.word;
		if (state.slot == SDL_SLOT_FIRST) begin
			next_state.word = word_in;
		end
		for (int l = 0; l < LANES; l++) begin
			next_state.lane[l].rise = source[l*8 + 2*int'(state.slot)];
			next_state.lane[l].fall = source[l*8 + 2*int'(state.slot) + 1];
		end
		next_state.fwd   = SDL_FWD_CLOCK;
		next_state.frame = (state.slot < SDL_FRAME_HIGH_SLOTS) ?
			SDL_DDR_HIGH : SDL_DDR_LOW;
		next_state.slot  = state.slot + SDL_SLOT_STEP;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign word_take_out = (state.slot == SDL_SLOT_FIRST);
	assign lane_out      = state.lane;
	assign fwd_clock_out = state.fwd;
	assign frame_out     = state.frame;

endmodule : sdl_four_lane_serializer

// ---- sdl_link_asserts.sv ----
/* checker for the serdes link top: transmit slots, frame, clock, fifo flags.
   assumes it is bound to the link top and sees only its ports. */
`timescale 1ns/1ps
module sdl_link_asserts
	import sdl_pkg::*;
#(
	parameter int         LANES       = SDL_LANES,
	parameter logic [7:0] PHASE_SHIFT = SDL_PHASE_QUARTER
) (
	input  wire logic                      clk_in,
	input  wire logic                      reset_n_in,
	input  wire logic [LANES*8-1:0]        tx_word_in,
	input  wire logic [SDL_SLICES-1:0]     tx_word_take_out,
	input  wire sdl_ddr_t [LANES-1:0]      tx_lane_out,
	input  wire sdl_ddr_t [SDL_SLICES-1:0] tx_fwd_clock_out,
	input  wire sdl_ddr_t [SDL_SLICES-1:0] tx_frame_out,
	input  wire logic [7:0]                rx_phase_shift_out,
	input  wire logic                      rx_read_in,
	input  wire logic                      rx_read_valid_out,
	input  wire logic                      rx_overflow_out,
	input  wire sdl_fill_t                 rx_fill_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	// ****************************************************************
	// transmit side
	// ****************************************************************
	// frame halves of one word, all slices together
	sequence s_frame_hi;
		tx_frame_out == 8'hff;
	endsequence
	sequence s_frame_lo;
		tx_frame_out == 8'h00;
	endsequence

	chk_take_period: assert property (
		tx_word_take_out[0] |=> (!tx_word_take_out[0]) [*3] ##1 tx_word_take_out[0])
		else $error("word take not once every four cycles");
	chk_slices_step: assert property (
		tx_word_take_out inside {4'h0, 4'hf})
		else $error("slices out of step");
	chk_frame_word: assert property (
		tx_word_take_out[0] |=> s_frame_hi [*2] ##1 s_frame_lo [*2])
		else $error("frame pattern wrong");
	// the first edge after release still shows the reset value
	chk_fwd_clock: assert property (
		$past(reset_n_in) |-> tx_fwd_clock_out == 8'haa)
		else $error("forwarded clock not high then low");
	chk_first_pair: assert property (
		tx_word_take_out[0] |=>
			tx_lane_out[0] == {$past(tx_word_in[0]), $past(tx_word_in[1])})
		else $error("lane 0 first pair wrong");
	chk_last_pair: assert property (
		tx_word_take_out[0] |-> ##4 tx_lane_out[LANES-1] ==
			{$past(tx_word_in[LANES*8-2], 4), $past(tx_word_in[LANES*8-1], 4)})
		else $error("top lane last pair wrong");

	// ****************************************************************
	// receive side
	// ****************************************************************
	chk_phase_fixed: assert property (
		$past(reset_n_in) |-> rx_phase_shift_out == PHASE_SHIFT)
		else $error("phase shift not fixed");
	chk_read_answer: assert property (
		rx_read_in && !rx_fill_out.empty |=> rx_read_valid_out)
		else $error("read not answered");
	chk_empty_read: assert property (
		rx_read_in && rx_fill_out.empty |=> !rx_read_valid_out)
		else $error("read at empty answered");
	chk_overflow_held: assert property (
		rx_overflow_out |=> rx_overflow_out)
		else $error("overflow dropped");
	chk_fill_order: assert property (
		(!rx_fill_out.half || rx_fill_out.quarter) &&
		(!rx_fill_out.three_quarter || rx_fill_out.half) &&
		(!rx_fill_out.full || rx_fill_out.three_quarter))
		else $error("fill flags out of order");
endmodule : sdl_link_asserts

bind sdl_ddr_serdes_link sdl_link_asserts #(
	.LANES      (LANES),
	.PHASE_SHIFT(PHASE_SHIFT)
) u_link_chk (
	.clk_in, .reset_n_in, .tx_word_in, .tx_word_take_out, .tx_lane_out,
	.tx_fwd_clock_out, .tx_frame_out, .rx_phase_shift_out, .rx_read_in,
	.rx_read_valid_out, .rx_overflow_out, .rx_fill_out
);

// ---- sdl_pkg.sv ----
/*
 * sdl_pkg: shared constants and carrier types for the 8:1 DDR serializer and
 * 1:8 deserializer backplane link.
 * Assumes one fully synchronous clock that carries one DDR bit pair per cycle.
 */
package sdl_pkg;

	// ****************************************************************
	// geometry
	// ****************************************************************
	localparam int SDL_LANES          = 16;
	localparam int SDL_SLICE_LANES    = 4;
	localparam int SDL_SLICES         = 4;
	localparam int SDL_BITS_PER_LANE  = 8;
	localparam int SDL_WORD_BITS      = 128;
	localparam int SDL_SLICE_BITS     = 32;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int SDL_CLK_MHZ        = 125;
	localparam int SDL_CLK_PERIOD_PS  = 1000000 / SDL_CLK_MHZ;
	// one word spans four quad-rate cycles, two bits per cycle
	localparam logic [1:0] SDL_SLOT_FIRST  = 2'h0;
	localparam logic [1:0] SDL_SLOT_LAST   = 2'h3;
	localparam logic [1:0] SDL_SLOT_STEP   = 2'h1;
	// frame is high for the first two slots: four of eight half periods
	localparam logic [1:0] SDL_FRAME_HIGH_SLOTS = 2'h2;

	// ****************************************************************
	// receive clock phase shift, in 1/256 steps of a period
	// ****************************************************************
	localparam int SDL_PHASE_STEPS    = 256;
	localparam int SDL_PHASE_DIVISOR  = 4;
	localparam logic [7:0] SDL_PHASE_QUARTER =
		8'(SDL_PHASE_STEPS / SDL_PHASE_DIVISOR);

	// ****************************************************************
	// receive fifo
	// ****************************************************************
	localparam int SDL_FIFO_ADDR_BITS = 9;

	// ****************************************************************
	// carriers
	// ****************************************************************
	typedef struct packed {
		logic rise;
		logic fall;
	} sdl_ddr_t;

	localparam sdl_ddr_t SDL_DDR_HIGH = 2'h3;
	localparam sdl_ddr_t SDL_DDR_LOW  = 2'h0;
	localparam sdl_ddr_t SDL_FWD_CLOCK = 2'h2;

	typedef struct packed {
		logic quarter;
		logic half;
		logic three_quarter;
		logic full;
		logic empty;
	} sdl_fill_t;

endpackage : sdl_pkg

// ---- sdl_rx_fifo.sv ----
/*
 * sdl_rx_fifo: receive word fifo with quarter, half and three-quarter fill
 * flags. The write side takes one word per write strobe.
 * Assumes writer and reader share clk_in; a word written while full is
 * dropped and flagged.
 */
`timescale 1ns/1ps
module sdl_rx_fifo
	import sdl_pkg::*;
#(
	parameter int WIDTH     = SDL_WORD_BITS,
	parameter int ADDR_BITS = SDL_FIFO_ADDR_BITS
) (
	input  wire logic                  clk_in,
	input  wire logic                  reset_n_in,
	input  wire logic                  write_in,
	input  wire logic [WIDTH-1:0]      write_data_in,
	input  wire logic                  read_in,
	output logic [WIDTH-1:0]           read_data_out,
	output logic                       read_valid_out,
	output logic                       overflow_out,
	output sdl_fill_t                  fill_out
);

	localparam logic [ADDR_BITS:0] DEPTH = (ADDR_BITS+1)'(1 << ADDR_BITS);

	typedef struct packed {
		logic [ADDR_BITS:0]  wr_ptr;
		logic [ADDR_BITS:0]  rd_ptr;
		logic [WIDTH-1:0]    rdata;
		logic                rvalid;
		logic                overflow;
	} sdl_fifo_state_t;

	sdl_fifo_state_t     state;
	sdl_fifo_state_t     next_state;
	logic [WIDTH-1:0]    mem [0:(1<<ADDR_BITS)-1];
	logic [ADDR_BITS:0]  level;
	logic                do_write;
	logic                do_read;

	// ****************************************************************
	// pointers and flags
	// ****************************************************************
	assign level    = state.wr_ptr - state.rd_ptr;
	assign do_write = write_in && (level != DEPTH);
	assign do_read  = read_in && (level != '0);

	always_comb begin
		next_state        = state;
		next_state.rvalid = do_read;
		if (do_write) begin
			next_state.wr_ptr = state.wr_ptr + 1'b1;
		end
		if (do_read) begin
			next_state.rd_ptr = state.rd_ptr + 1'b1;
			next_state.rdata  = mem[state.rd_ptr[ADDR_BITS-1:0]];
		end
		// sticky so software-free logic can still see a lost word
		if (write_in && (level == DEPTH)) begin
			next_state.overflow = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// storage carries no reset so it can map onto block memory
	always_ff @(posedge clk_in) begin
		if (do_write) begin
			mem[state.wr_ptr[ADDR_BITS-1:0]] <= write_data_in;
		end
	end

	// fill flags compare the level against fixed fractions of the depth
	always_comb begin
		fill_out.quarter       = level >= (DEPTH >> 2);
		fill_out.half          = level >= (DEPTH >> 1);
		fill_out.three_quarter = level >= ((DEPTH >> 1) + (DEPTH >> 2));
		fill_out.full          = level == DEPTH;
		fill_out.empty         = level == '0;
	end

	assign read_data_out  = state.rdata;
	assign read_valid_out = state.rvalid;
	assign overflow_out   = state.overflow;

endmodule : sdl_rx_fifo
